// >>> pcpc_regs.vh
`ifndef PCPC_REGS_VH
`define PCPC_REGS_VH

// ----------------------------------------------------------------
// Target address
// ----------------------------------------------------------------
`define PCPC_ADDR_FIXED 5'h13

// ----------------------------------------------------------------
// Register offsets within a page
// ----------------------------------------------------------------
`define PCPC_PAGE_SELECT 8'h00
`define PCPC_DEVICE_CTRL 8'h03
`define PCPC_XOR_CHECKSUM 8'h7D
`define PCPC_CRC_CHECKSUM 8'h7E
`define PCPC_BOOK_SELECT 8'h7F

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PCPC_STATE_MSB 1
`define PCPC_STATE_LSB 0
`define PCPC_STATE_DEEP_SLEEP 2'h0
`define PCPC_STATE_SLEEP 2'h1
`define PCPC_STATE_HIZ 2'h2
`define PCPC_STATE_PLAY 2'h3
`define PCPC_PAGE_RESET 8'h00
`define PCPC_BOOK_RESET 8'h00
`define PCPC_CHECKSUM_RESET 8'h00

// ----------------------------------------------------------------
// Books and checksum constants
// ----------------------------------------------------------------
`define PCPC_BOOK_MAIN 8'h00
`define PCPC_BOOK_XOR 8'h8C
`define PCPC_BOOK_BIQUAD 8'hAA
`define PCPC_CRC_POLY 8'h07

`endif

// >>> pcpc_control_port.v
`timescale 1ns/1ps
`include "pcpc_regs.vh"

module pcpc_control_port (
  input wire clk_in,
  input wire rst_in,
  input wire scl_in,
  input wire sda_in,
  input wire [1:0] adr_strap_in,
  output wire sda_out,
  output wire sda_oe_out,
  output wire [7:0] page_out,
  output wire [7:0] book_out,
  output wire [1:0] device_state_out,
  output wire [7:0] crc_out,
  output wire [7:0] xor_out
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_SUB = 7'h04;
  localparam [6:0] ST_WDAT = 7'h08;
  localparam [6:0] ST_ACK = 7'h10;
  localparam [6:0] ST_RDAT = 7'h20;
  localparam [6:0] ST_MACK = 7'h40;

  reg [6:0] state_r;
  reg [6:0] after_r;
  reg [2:0] cnt_r;
  reg [7:0] sh_r;
  reg full_r;
  reg host_ack_r;
  reg [7:0] sub_r;
  reg scl_q_r;
  reg sda_q_r;
  reg sda_out_r;
  reg sda_oe_r;
  reg [1:0] strap_r;
  reg strap_done_r;
  reg [7:0] page_r;
  reg [7:0] book_r;
  reg [1:0] dev_state_r;
  reg [7:0] crc_r;
  reg [7:0] xor_r;
  reg [7:0] mem [0:127];

  // ----------------------------------------------------------------
  // Bus events, sampled at the core clock
  // ----------------------------------------------------------------
  wire scl_rise = scl_in & ~scl_q_r;
  wire scl_fall = ~scl_in & scl_q_r;
  wire bus_start = scl_in & scl_q_r & sda_q_r & ~sda_in;
  wire bus_stop = scl_in & scl_q_r & ~sda_q_r & sda_in;
  wire addr_hit = (sh_r[7:1] == {`PCPC_ADDR_FIXED, strap_r});

  // Write decode of the current subaddress
  wire on_page0 = (page_r == 8'h00);
  wire is_page_wr = (sub_r == `PCPC_PAGE_SELECT);
  wire is_book_wr = on_page0 && (sub_r == `PCPC_BOOK_SELECT);
  wire is_crc_rst = on_page0 && (sub_r == `PCPC_CRC_CHECKSUM) && (sh_r == 8'h00);
  wire is_xor_rst = on_page0 && (book_r == `PCPC_BOOK_XOR) && (sub_r == `PCPC_XOR_CHECKSUM) && (sh_r == 8'h00);
  wire xor_covers = (book_r == `PCPC_BOOK_XOR) && !on_page0 && !is_page_wr;

  // CRC step, MSB first, polynomial x^8+x^2+x+1
  function [7:0] crc_step;
    input [7:0] crc;
    input [7:0] data;
    integer i;
    reg [7:0] x;
    begin
      x = crc ^ data;
      for (i = 0; i < 8; i = i + 1)
        x = x[7] ? ({x[6:0], 1'b0} ^ `PCPC_CRC_POLY) : {x[6:0], 1'b0};
      crc_step = x;
    end
  endfunction

  // ----------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------
  // Only page 0 of the main book is backed by storage; elsewhere page 0 reads back page, book, CRC, XOR in XOR book, other pages only page select, rest zero
  reg [7:0] rd_data;
  always @*
  begin
    rd_data = 8'h00;
    if (sub_r == `PCPC_PAGE_SELECT)
      rd_data = page_r;
    else if (on_page0 && sub_r == `PCPC_BOOK_SELECT)
      rd_data = book_r;
    else if (on_page0 && sub_r == `PCPC_CRC_CHECKSUM)
      rd_data = crc_r;
    else if (on_page0 && book_r == `PCPC_BOOK_XOR && sub_r == `PCPC_XOR_CHECKSUM)
      rd_data = xor_r;
    else if (on_page0 && book_r == `PCPC_BOOK_MAIN && sub_r == `PCPC_DEVICE_CTRL)
      rd_data = {mem[sub_r[6:0]][7:2], dev_state_r};
    else if (on_page0 && book_r == `PCPC_BOOK_MAIN && !sub_r[7])
      rd_data = mem[sub_r[6:0]];
  end

  // ----------------------------------------------------------------
  // Register storage, written on each accepted data byte to offsets 0x00-0x7F of page 0 of the main book
  // ----------------------------------------------------------------
  // Array kept unreset to map onto RAM; control fields are separate flops
  wire wr_byte = (state_r == ST_WDAT) && full_r && scl_fall;
  always @(posedge clk_in)
  begin
    if (wr_byte && on_page0 && book_r == `PCPC_BOOK_MAIN && !sub_r[7])
      mem[sub_r[6:0]] <= sh_r;
  end

  // ----------------------------------------------------------------
  // Control registers and checksums
  // ----------------------------------------------------------------
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      page_r <= `PCPC_PAGE_RESET;
      book_r <= `PCPC_BOOK_RESET;
      dev_state_r <= `PCPC_STATE_DEEP_SLEEP;
      crc_r <= `PCPC_CHECKSUM_RESET;
      xor_r <= `PCPC_CHECKSUM_RESET;
    end
    else if (wr_byte)
    begin
      if (is_page_wr)
        page_r <= sh_r;
      if (is_book_wr)
        book_r <= sh_r;
      if (on_page0 && book_r == `PCPC_BOOK_MAIN && sub_r == `PCPC_DEVICE_CTRL)
        dev_state_r <= sh_r[`PCPC_STATE_MSB:`PCPC_STATE_LSB];
      // Every other write, even to empty space, moves the CRC
      if (is_crc_rst)
        crc_r <= `PCPC_CHECKSUM_RESET;
      else if (!is_page_wr && !is_book_wr)
        crc_r <= crc_step(crc_r, sh_r);
      if (is_xor_rst)
        xor_r <= `PCPC_CHECKSUM_RESET;
      else if (xor_covers)
        xor_r <= xor_r ^ sh_r;
    end
  end

  // ----------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------
  // Strap decoded externally to two bits: 0R=00, 1k=01, 4.7k=10, 15k=11
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      strap_r <= 2'h0;
      strap_done_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      strap_r <= adr_strap_in;
      strap_done_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Bus engine
  // ----------------------------------------------------------------
  // Core clock oversamples SCL 500x at 400 kHz, so both rates just work
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_r <= ST_IDLE;
      after_r <= ST_IDLE;
      cnt_r <= 3'h0;
      sh_r <= 8'h00;
      full_r <= 1'b0;
      host_ack_r <= 1'b0;
      sub_r <= 8'h00;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      sda_out_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else
    begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
      if (bus_start)
      begin
        state_r <= ST_ADDR;
        cnt_r <= 3'h0;
        full_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end
      else if (bus_stop)
      begin
        state_r <= ST_IDLE;
        sda_oe_r <= 1'b0;
      end
      else
      begin
        case (state_r)
          ST_ADDR, ST_SUB, ST_WDAT:
          begin
            if (scl_rise)
            begin
              sh_r <= {sh_r[6:0], sda_in};
              cnt_r <= cnt_r + 3'h1;
              if (cnt_r == 3'h7)
                full_r <= 1'b1;
            end
            else if (scl_fall && full_r)
            begin
              full_r <= 1'b0;
              if (state_r == ST_ADDR && !addr_hit)
                state_r <= ST_IDLE;
              else
              begin
                sda_oe_r <= 1'b1;
                state_r <= ST_ACK;
                if (state_r == ST_ADDR)
                  after_r <= sh_r[0] ? ST_RDAT : ST_SUB;
                else
                  after_r <= ST_WDAT;
                if (state_r == ST_SUB)
                  sub_r <= sh_r;
                if (state_r == ST_WDAT)
                  sub_r <= sub_r + 8'h01;
              end
            end
          end
          ST_ACK:
          begin
            if (scl_fall)
            begin
              cnt_r <= 3'h0;
              state_r <= after_r;
              if (after_r == ST_RDAT)
              begin
                sh_r <= {rd_data[6:0], 1'b0};
                sda_oe_r <= ~rd_data[7];
                sub_r <= sub_r + 8'h01;
              end
              else
                sda_oe_r <= 1'b0;
            end
          end
          ST_RDAT:
          begin
            if (scl_rise)
              cnt_r <= cnt_r + 3'h1;
            else if (scl_fall)
            begin
              if (cnt_r == 3'h0)
              begin
                sda_oe_r <= 1'b0;
                state_r <= ST_MACK;
              end
              else
              begin
                sda_oe_r <= ~sh_r[7];
                sh_r <= {sh_r[6:0], 1'b0};
              end
            end
          end
          ST_MACK:
          begin
            if (scl_rise)
              host_ack_r <= ~sda_in;
            else if (scl_fall)
            begin
              if (host_ack_r)
              begin
                cnt_r <= 3'h0;
                sh_r <= {rd_data[6:0], 1'b0};
                sda_oe_r <= ~rd_data[7];
                sub_r <= sub_r + 8'h01;
                state_r <= ST_RDAT;
              end
              else
                state_r <= ST_IDLE;
            end
          end
          ST_IDLE:
            sda_oe_r <= 1'b0;
          default:
          begin
            state_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open drain: only ever pulls low
  assign sda_out = sda_out_r;
  assign sda_oe_out = sda_oe_r;
  assign page_out = page_r;
  assign book_out = book_r;
  assign device_state_out = dev_state_r;
  assign crc_out = crc_r;
  assign xor_out = xor_r;

endmodule

// >>> pcpc_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// I2C host controller model
// ----------------------------------------
module pcpc_host_model (
  input wire clk_in,
  input wire sda_in,
  output logic scl_out,
  output logic sda_pull_out,
  output logic done_out,
  output logic [7:0] rx_out,
  output logic ack_out
);
  // Idle bus: both lines released
  initial
  begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
    done_out = 1'b0;
    rx_out = 8'h00;
    ack_out = 1'b0;
  end
  // Lines move one fixed delay after a core edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Start from idle, or repeated start with SCL low
  task automatic start();
    sda_pull_out = 1'b0;
    step(4);
    scl_out = 1'b1;
    step(4);
    sda_pull_out = 1'b1;
    step(4);
    scl_out = 1'b0;
  endtask
  // Stop: data rises while clock is high
  task automatic stop();
    step(2);
    sda_pull_out = 1'b1;
    step(2);
    scl_out = 1'b1;
    step(4);
    sda_pull_out = 1'b0;
    step(4);
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ack_bit);
    for (int i = 8; i >= 0; i--)
    begin
      step(2);
      sda_pull_out = (i == 0) ? !ack_bit : !tx[i-1];
      step(2);
      scl_out = 1'b1;
      step(2);
      if (i > 0) rx_out[i-1] = sda_in;
      else ack_out = !sda_in;
      step(2);
      scl_out = 1'b0;
    end
    done_out = 1'b1;
    step(1);
    done_out = 1'b0;
  endtask
endmodule

// >>> pcpc_control_port_chk.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module pcpc_control_port_chk (
  input wire clk_in,
  input wire rst_in,
  input wire scl_in,
  input wire sda_in,
  input wire [1:0] adr_strap_in,
  input wire sda_out,
  input wire sda_oe_out,
  input wire [7:0] page_out,
  input wire [7:0] book_out,
  input wire [1:0] device_state_out,
  input wire [7:0] crc_out,
  input wire [7:0] xor_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Drive timing: enable moves only at the first clock edge after an SCL fall
  a_pin_open_drain: assert property (sda_out == 1'b0)
    else $error("sda_out not low");
  a_oe_after_fall: assert property ($changed(sda_oe_out) |-> !$past(scl_in) && $past(scl_in, 2))
    else $error("sda_oe_out moved off the fall timing");
  a_ack_stands: assert property ($rose(sda_oe_out) |-> sda_oe_out [*6])
    else $error("drive released early");
  a_oe_bounded: assert property (sda_oe_out |-> ##[1:100] !sda_oe_out)
    else $error("drive held too long");
  a_reset_quiet: assert property (@(posedge clk_in) disable iff (1'b0)
    rst_in && $past(rst_in) |-> !sda_oe_out && crc_out == 8'h00 && xor_out == 8'h00 && page_out == 8'h00)
    else $error("outputs not cleared in reset");
  // Register outputs only change at the acknowledge edge
  a_state_at_ack: assert property ($changed(device_state_out) |-> $rose(sda_oe_out))
    else $error("state changed outside ack");
  a_crc_at_ack: assert property ($changed(crc_out) |-> $rose(sda_oe_out))
    else $error("crc changed outside ack");
  a_xor_at_ack: assert property ($changed(xor_out) |-> $rose(sda_oe_out))
    else $error("xor changed outside ack");
  a_page_at_ack: assert property ($changed(page_out) |-> $rose(sda_oe_out))
    else $error("page changed outside ack");
  a_book_at_ack: assert property ($changed(book_out) |-> $rose(sda_oe_out))
    else $error("book changed outside ack");
  c_ack_seen: cover property ($rose(sda_oe_out));
  c_crc_moves: cover property ($changed(crc_out));
  c_xor_moves: cover property ($changed(xor_out));
endmodule

// >>> tb_paged_control_port_checksum.sv
`timescale 1ns/1ps
`include "pcpc_regs.vh"
// ----------------------------------------
// Bench top
// ----------------------------------------
module tb_paged_control_port_checksum;
  typedef struct {logic is_ack; logic [7:0] val;} pcpc_note_t;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [1:0] strap = 2'h0;
  wire sda;
  wire scl, pull, done, ack, sda_out, sda_oe;
  wire [7:0] rx, page_out, book_out, crc_out, xor_out;
  wire [1:0] state_out;
  pcpc_note_t notes[$];
  pcpc_note_t cur;
  logic [7:0] mem [0:127];
  logic [7:0] page, book, crc, xs;
  logic [7:0] lfsr = 8'h5D;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  // Open-drain line with pull-up
  assign sda = !(pull || sda_oe);
  initial forever #2.5 clk_in = !clk_in;
  pcpc_control_port dut (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda), .adr_strap_in(strap),
    .sda_out(sda_out), .sda_oe_out(sda_oe), .page_out(page_out), .book_out(book_out),
    .device_state_out(state_out), .crc_out(crc_out), .xor_out(xor_out));
  pcpc_host_model host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_pull_out(pull), .done_out(done),
    .rx_out(rx), .ack_out(ack));
  task automatic end_of_test();
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_ack(input logic g, input logic e);
    cmp_byte({7'h00, g}, {7'h00, e});
  endtask
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction
  // Reference CRC, MSB first, no reflection
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? ({r[6:0], 1'b0} ^ `PCPC_CRC_POLY) : {r[6:0], 1'b0};
    return r;
  endfunction
  // Expected effect of one written byte
  function automatic void upd(input logic [7:0] a, input logic [7:0] d);
    if (a == `PCPC_PAGE_SELECT) page = d;
    else if (page == 8'h00 && a == `PCPC_BOOK_SELECT) book = d;
    else if (page == 8'h00 && a == `PCPC_CRC_CHECKSUM && d == 8'h00) crc = 8'h00;
    else
    begin
      crc = crc8(crc, d);
      if (book == `PCPC_BOOK_XOR && page != 8'h00) xs = xs ^ d;
      if (book == `PCPC_BOOK_XOR && page == 8'h00 && a == `PCPC_XOR_CHECKSUM && d == 8'h00) xs = 8'h00;
      if (book == 8'h00 && page == 8'h00 && !a[7]) mem[a[6:0]] = d;
    end
  endfunction
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (a == `PCPC_PAGE_SELECT) return page;
    if (page != 8'h00) return 8'h00;
    if (a == `PCPC_BOOK_SELECT) return book;
    if (a == `PCPC_CRC_CHECKSUM) return crc;
    if (a == `PCPC_XOR_CHECKSUM && book == `PCPC_BOOK_XOR) return xs;
    return (book == 8'h00 && !a[7]) ? mem[a[6:0]] : 8'h00;
  endfunction
  task automatic send(input logic [7:0] b, input logic e);
    notes.push_back('{1'b1, {7'h00, e}});
    host.xfer(b, 1'b1);
  endtask
  task automatic wr(input logic [7:0] sub, input logic [7:0] d[$]);
    host.start();
    send({`PCPC_ADDR_FIXED, strap, 1'b0}, 1'b1);
    send(sub, 1'b1);
    foreach (d[i])
    begin
      send(d[i], 1'b1);
      upd(sub + 8'(i), d[i]);
    end
    host.stop();
  endtask
  task automatic rd(input logic [7:0] sub, input int n);
    host.start();
    send({`PCPC_ADDR_FIXED, strap, 1'b0}, 1'b1);
    send(sub, 1'b1);
    host.start();
    send({`PCPC_ADDR_FIXED, strap, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      notes.push_back('{1'b0, exp_rd(sub + 8'(i))});
      host.xfer(8'hFF, i == n - 1);
    end
    host.stop();
  endtask
  task automatic do_reset(input logic [1:0] s);
    strap = s;
    rst_in = 1'b1;
    {page, book, crc, xs} = 32'h0;
    repeat (8) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    // Reset release stands in for the power-down pin; no frame before it settles
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  // Watcher: oldest note against each finished byte, plus the hang limit
  always @(posedge clk_in)
  begin
    cycles++;
    if (done === 1'b1 && notes.size() > 0)
    begin
      cur = notes.pop_front();
      if (cur.is_ack) cmp_ack(ack, cur.val[0]);
      else cmp_byte(rx, cur.val);
    end
    if (cycles == 40000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  // Main sequence
  initial
  begin
    for (int s = 0; s < 4; s++)
    begin
      do_reset(2'(s));
      host.start();
      send({`PCPC_ADDR_FIXED, 2'(s), 1'b0}, 1'b1);
      host.start();
      send({`PCPC_ADDR_FIXED, 2'(s) ^ 2'h1, 1'b0}, 1'b0);
      host.start();
      send({5'h03, 2'(s), 1'b0}, 1'b0);
      host.stop();
    end
    for (int st = 0; st < 4; st++)
    begin
      wr(`PCPC_DEVICE_CTRL, '{8'(st)});
      cmp_byte({6'h00, state_out}, 8'(st));
    end
    // Shutdown path: back to high impedance before supplies drop
    wr(`PCPC_DEVICE_CTRL, '{8'h02});
    cmp_byte({6'h00, state_out}, 8'h02);
    wr(8'h10, '{rnd(), rnd(), rnd()});
    cmp_byte(crc_out, crc);
    rd(8'h10, 3);
    cmp_byte(crc_out, crc);
    wr(`PCPC_PAGE_SELECT, '{8'hFF});
    cmp_byte(page_out, 8'hFF);
    rd(`PCPC_PAGE_SELECT, 1);
    cmp_byte(crc_out, crc);
    wr(`PCPC_PAGE_SELECT, '{8'h00});
    wr(`PCPC_BOOK_SELECT, '{`PCPC_BOOK_XOR});
    cmp_byte(book_out, `PCPC_BOOK_XOR);
    rd(`PCPC_BOOK_SELECT, 1);
    wr(`PCPC_PAGE_SELECT, '{8'h01});
    wr(8'h08, '{rnd(), rnd(), rnd()});
    cmp_byte(xor_out, xs);
    wr(`PCPC_PAGE_SELECT, '{8'h00});
    wr(8'h20, '{rnd()});
    cmp_byte(xor_out, xs);
    rd(`PCPC_XOR_CHECKSUM, 2);
    wr(`PCPC_XOR_CHECKSUM, '{8'h00, 8'h00});
    cmp_byte(xor_out, 8'h00);
    cmp_byte(crc_out, 8'h00);
    // Biquad load from page 0: book, page, then five coefficients ascending
    wr(`PCPC_BOOK_SELECT, '{`PCPC_BOOK_BIQUAD});
    cmp_byte(book_out, `PCPC_BOOK_BIQUAD);
    wr(`PCPC_PAGE_SELECT, '{8'h02});
    wr(8'h18, '{rnd(), rnd(), rnd(), rnd(), rnd()});
    cmp_byte(crc_out, crc);
    cmp_byte(xor_out, 8'h00);
    cmp_byte(8'(notes.size()), 8'h00);
    end_of_test();
  end
endmodule
bind pcpc_control_port pcpc_control_port_chk chk (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_in),
  .sda_in(sda_in), .adr_strap_in(adr_strap_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .page_out(page_out), .book_out(book_out), .device_state_out(device_state_out), .crc_out(crc_out),
  .xor_out(xor_out));
